// [hpp_config_regs.sv]
// Hub port power configuration register bank with derived settings.
// Assumes a serial slave engine outside presents byte-wide register
// accesses (address, write strobe, data) synchronous to clock_i.
module hpp_config_regs
	import hpp_pkg::*;
#(
	parameter int NUM_PORTS = 2,
	parameter int CYC_0     = HPP_DELAY_CYC_0,
	parameter int CYC_1     = HPP_DELAY_CYC_1,
	parameter int CYC_2     = HPP_DELAY_CYC_2,
	parameter int CYC_3     = HPP_DELAY_CYC_3
) (
	input  wire logic                 clock_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 clk_en_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic                 reg_wr_i,
	input  wire logic [7:0]           reg_wdata_i,
	output logic [7:0]                reg_rdata_o,
	input  wire logic                 local_power_sense_pin_i,
	input  wire logic                 overload_raw_i,
	output logic                      self_powered_o,
	output logic                      fast_mode_inhibit_o,
	output logic                      frame_end_packet_suppress_o,
	output logic [1:0]                overload_sense_mode_o,
	output logic                      overload_sense_on_o,
	output logic                      overload_o,
	output logic                      compound_o,
	output logic [NUM_PORTS:1]        fixed_port_bits_o,
	output logic [NUM_PORTS:1]        port_enabled_o,
	output logic [9:0]                max_draw_local_ma_o,
	output logic                      config_locked_o
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] hub_config_byte_one_q;
	logic [7:0] hub_config_byte_two_q;
	logic [7:0] fixed_port_mask_q;
	logic [7:0] port_off_mask_local_power_q;
	logic [7:0] port_off_mask_upstream_power_q;
	logic [7:0] max_draw_local_power_q;
	logic       config_lock_bit_q;
	logic       cfg_wr;
	logic       power_mode_d;
	logic [7:0] port_mask_d;

	// Address inside the lockable configuration range
	function automatic logic in_lock_range(input logic [7:0] a);
		in_lock_range = (a >= HPP_OFS_LOCK_LO) && (a <= HPP_OFS_LOCK_HI);
	endfunction

	// Port-defining registers keep only bits 1 and 2
	function automatic logic [7:0] port_bits(input logic [7:0] d);
		port_bits = d & HPP_MASK_PORTS;
	endfunction

	// ------------------------------------------------------------
	// Write qualification
	// ------------------------------------------------------------
	// lock blocks writes
	assign cfg_wr = reg_wr_i && clk_en_i && !config_lock_bit_q
	                && in_lock_range(reg_addr_i);

	// Lock bit is write once; only hardware reset clears it
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			config_lock_bit_q <= 1'b0;
		end else if (clk_en_i && reg_wr_i
		             && reg_addr_i == HPP_OFS_STATUS
		             && reg_wdata_i[HPP_BIT_LOCK]) begin
			config_lock_bit_q <= 1'b1;
		end
	end

	// Configuration registers; reserved bits are never stored so they
	// read back zero even if the host disobeys the zero-write policy.
	// reset to zero
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hub_config_byte_one_q          <= HPP_RESET_VALUE;
			hub_config_byte_two_q          <= HPP_RESET_VALUE;
			fixed_port_mask_q              <= HPP_RESET_VALUE;
			port_off_mask_local_power_q    <= HPP_RESET_VALUE;
			port_off_mask_upstream_power_q <= HPP_RESET_VALUE;
			max_draw_local_power_q         <= HPP_RESET_VALUE;
		end else if (cfg_wr) begin
			case (reg_addr_i)
				HPP_OFS_CFG_ONE: begin
					hub_config_byte_one_q <= reg_wdata_i & HPP_MASK_CFG_ONE;
				end
				HPP_OFS_CFG_TWO: begin
					hub_config_byte_two_q <= reg_wdata_i & HPP_MASK_CFG_TWO;
				end
				HPP_OFS_FIXED: begin
					fixed_port_mask_q <= port_bits(reg_wdata_i);
				end
				HPP_OFS_OFF_LOCAL: begin
					port_off_mask_local_power_q <= port_bits(reg_wdata_i);
				end
				HPP_OFS_OFF_UP: begin
					port_off_mask_upstream_power_q <= port_bits(reg_wdata_i);
				end
				HPP_OFS_MAX_LOCAL: begin
					max_draw_local_power_q <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Undefined or out-of-bank addresses read zero
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= HPP_RESET_VALUE;
		end else if (clk_en_i) begin
			case (reg_addr_i)
				HPP_OFS_STATUS:    reg_rdata_o <= {6'b0, config_lock_bit_q, 1'b0};
				HPP_OFS_CFG_ONE:   reg_rdata_o <= hub_config_byte_one_q;
				HPP_OFS_CFG_TWO:   reg_rdata_o <= hub_config_byte_two_q;
				HPP_OFS_FIXED:     reg_rdata_o <= fixed_port_mask_q;
				HPP_OFS_OFF_LOCAL: reg_rdata_o <= port_off_mask_local_power_q;
				HPP_OFS_OFF_UP:    reg_rdata_o <= port_off_mask_upstream_power_q;
				HPP_OFS_MAX_LOCAL: reg_rdata_o <= max_draw_local_power_q;
				default:           reg_rdata_o <= HPP_RESET_VALUE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Power mode resolution
	// ------------------------------------------------------------
	always_comb begin
		if (hub_config_byte_two_q[HPP_BIT_DYNAMIC]) begin
			power_mode_d = local_power_sense_pin_i;
		end else begin
			power_mode_d = hub_config_byte_one_q[HPP_BIT_SRC_SEL];
		end
	end

	// Registered mode; the pin is taken as already synchronous
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			self_powered_o <= 1'b0;
		end else if (clk_en_i) begin
			self_powered_o <= power_mode_d;
		end
	end

	// ------------------------------------------------------------
	// Port availability
	// ------------------------------------------------------------
	// mask by mode
	assign port_mask_d = power_mode_d ? port_off_mask_local_power_q
	                                  : port_off_mask_upstream_power_q;

	genvar gp;
	generate
		for (gp = 1; gp <= NUM_PORTS; gp++) begin : g_port
			always_ff @(posedge clock_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					port_enabled_o[gp]    <= 1'b0;
					fixed_port_bits_o[gp] <= 1'b0;
				end else if (clk_en_i) begin
					port_enabled_o[gp]    <= !port_mask_d[gp];
					fixed_port_bits_o[gp] <= fixed_port_mask_q[gp];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Static settings driven out
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fast_mode_inhibit_o         <= 1'b0;
			frame_end_packet_suppress_o <= 1'b0;
			overload_sense_mode_o       <= HPP_SENSE_GANGED;
			overload_sense_on_o         <= 1'b0;
			compound_o                  <= 1'b0;
			max_draw_local_ma_o         <= '0;
			config_locked_o             <= 1'b0;
		end else if (clk_en_i) begin
			fast_mode_inhibit_o <=
				hub_config_byte_one_q[HPP_BIT_FAST_INH];
			frame_end_packet_suppress_o <=
				hub_config_byte_one_q[HPP_BIT_EOP_SUPP];
			overload_sense_mode_o <=
				hub_config_byte_one_q[HPP_BIT_SENSE_LO +: 2];
			overload_sense_on_o <=
				(hub_config_byte_one_q[HPP_BIT_SENSE_LO +: 2]
				 == HPP_SENSE_GANGED);
			compound_o <= hub_config_byte_two_q[HPP_BIT_COMPOUND];
			max_draw_local_ma_o <= 10'(max_draw_local_power_q * HPP_MA_PER_STEP);
			config_locked_o     <= config_lock_bit_q;
		end
	end

	// ------------------------------------------------------------
	// Overload qualification
	// ------------------------------------------------------------
	logic overload_q;

	hpp_overload_timer #(
		.CYC_0 (CYC_0),
		.CYC_1 (CYC_1),
		.CYC_2 (CYC_2),
		.CYC_3 (CYC_3)
	) u_timer (
		.clock_i     (clock_i),
		.sys_rst_i   (sys_rst_i),
		.clk_en_i    (clk_en_i),
		.delay_sel_i (hub_config_byte_two_q[HPP_BIT_DELAY_LO +: 2]),
		.raw_i       (overload_raw_i && overload_sense_on_o),
		.qualified_o (overload_q)
	);

	// Unsupported sensing never reports overload
	assign overload_o = overload_q;

endmodule

// [hpp_config_regs_chk.sv]
// Concurrent checks on the configuration bank ports.
// Assumes every port is visible at the bind and one clock domain.
module hpp_config_regs_chk
	import hpp_pkg::*;
#(
	parameter int NUM_PORTS = 2
) (
	input wire logic                 clock_i,
	input wire logic                 sys_rst_i,
	input wire logic                 clk_en_i,
	input wire logic [7:0]           reg_addr_i,
	input wire logic                 reg_wr_i,
	input wire logic [7:0]           reg_wdata_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire logic                 local_power_sense_pin_i,
	input wire logic                 overload_raw_i,
	input wire logic                 self_powered_o,
	input wire logic                 fast_mode_inhibit_o,
	input wire logic                 frame_end_packet_suppress_o,
	input wire logic [1:0]           overload_sense_mode_o,
	input wire logic                 overload_sense_on_o,
	input wire logic                 overload_o,
	input wire logic                 compound_o,
	input wire logic [NUM_PORTS:1]   fixed_port_bits_o,
	input wire logic [NUM_PORTS:1]   port_enabled_o,
	input wire logic [9:0]           max_draw_local_ma_o,
	input wire logic                 config_locked_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// ------------------------------------------------------------
	// Write landing: derived outputs follow two edges later
	// ------------------------------------------------------------
	// Lock test in the antecedent, since a locked write is dropped
	sequence wr_to(logic [7:0] a);
		clk_en_i && reg_wr_i && reg_addr_i == a && !config_locked_o
		##1 clk_en_i;
	endsequence
	AST_FAST: assert property (wr_to(HPP_OFS_CFG_ONE) |-> ##1
		fast_mode_inhibit_o == $past(reg_wdata_i[5], 2))
		else $error("fast mode inhibit not taken from write");
	AST_EOP: assert property (wr_to(HPP_OFS_CFG_ONE) |-> ##1
		frame_end_packet_suppress_o == $past(reg_wdata_i[3], 2))
		else $error("end packet suppress not taken from write");
	AST_SENSE: assert property (wr_to(HPP_OFS_CFG_ONE) |-> ##1
		overload_sense_mode_o == $past(reg_wdata_i[2:1], 2) &&
		overload_sense_on_o == ($past(reg_wdata_i[2:1], 2) == 2'b00))
		else $error("sense mode not taken from write");
	AST_COMPOUND: assert property (wr_to(HPP_OFS_CFG_TWO) |-> ##1
		compound_o == $past(reg_wdata_i[3], 2))
		else $error("compound flag not taken from write");
	AST_FIXED: assert property (wr_to(HPP_OFS_FIXED) |-> ##1
		fixed_port_bits_o == $past(reg_wdata_i[2:1], 2))
		else $error("fixed port bits not taken from write");
	AST_MAXDRAW: assert property (wr_to(HPP_OFS_MAX_LOCAL) |-> ##1
		max_draw_local_ma_o == {1'b0, $past(reg_wdata_i, 2), 1'b0})
		else $error("max draw not twice the written value");
	AST_LOCK: assert property (config_locked_o |=> config_locked_o)
		else $error("lock cleared without reset");
	AST_LOCK_HOLD: assert property (config_locked_o |=>
		$stable(fast_mode_inhibit_o) && $stable(max_draw_local_ma_o) &&
		$stable(compound_o))
		else $error("setting changed while locked");
	AST_RESET: assert property ($past(sys_rst_i) |->
		reg_rdata_o == 8'h00 && max_draw_local_ma_o == 10'h000 &&
		!self_powered_o && !config_locked_o)
		else $error("outputs not clear after reset");
	AST_OVL_RISE: assert property ($rose(overload_o) |->
		$past(overload_raw_i) && $past(overload_raw_i, 3))
		else $error("overload rose without raw held");
	AST_OVL_FALL: assert property (!overload_raw_i ##1 !overload_raw_i
		|-> ##1 !overload_o)
		else $error("overload held after raw fell");
	// Main scenarios reached
	COV_LOCK: cover property ($rose(config_locked_o));
	COV_OVL: cover property ($rose(overload_o));
	COV_CFG: cover property (wr_to(HPP_OFS_CFG_ONE));
endmodule
bind hpp_config_regs hpp_config_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// [hpp_host_model.sv]
// Serial host model presenting decoded byte register accesses.
// Assumes the bank samples address and strobe on clock_i rising edges.
module hpp_host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] rdata_i,
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	// One strobe edge; released data inverted so stale data never matches
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wr_o <= 1'b1;
		wdata_o <= d;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// Registered read data, taken just after the sampling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		@(posedge clock_i);
		#1 d = rdata_i;
	endtask
endmodule

// [hpp_overload_timer.sv]
// Overload qualification timer: a raw overload flag must hold for the
// programmed delay before the qualified flag rises.
// Assumes the raw flag is synchronous to clock_i.
module hpp_overload_timer
	import hpp_pkg::*;
#(
	parameter int CYC_0 = HPP_DELAY_CYC_0,
	parameter int CYC_1 = HPP_DELAY_CYC_1,
	parameter int CYC_2 = HPP_DELAY_CYC_2,
	parameter int CYC_3 = HPP_DELAY_CYC_3
) (
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	input  wire logic       clk_en_i,
	input  wire logic [1:0] delay_sel_i,
	input  wire logic       raw_i,
	output logic            qualified_o
);

	logic [HPP_DELAY_W-1:0] count_q;
	logic [HPP_DELAY_W-1:0] limit;

	// Delay selection
	always_comb begin
		case (delay_sel_i)
			2'b00:   limit = HPP_DELAY_W'(CYC_0);
			2'b01:   limit = HPP_DELAY_W'(CYC_1);
			2'b10:   limit = HPP_DELAY_W'(CYC_2);
			default: limit = HPP_DELAY_W'(CYC_3);
		endcase
	end

	// Count while raw flag holds; a glitch restarts the wait
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_q     <= '0;
			qualified_o <= 1'b0;
		end else if (clk_en_i) begin
			if (!raw_i) begin
				count_q     <= '0;
				qualified_o <= 1'b0;
			end else if (count_q >= limit - 1'b1) begin
				qualified_o <= 1'b1;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

endmodule

// [hpp_pkg.sv]
// Constants shared by the hub port power configuration register bank.
// Assumes a byte-wide register port driven by an external serial slave
// engine that presents one decoded register access per clock.
//
// Notes on behaviour
// - Config one bit 7 picks power mode: 0 bus, 1 self powered.
// - With dynamic switching on, sense pin decides power mode, not bit 7.
// - Config one bit 5 set forces full-speed-only attachment.
// - Config one bit 3 set suppresses end-of-packet at EOF1 in full speed.
// - Overload sense field 2:1: 00 ganged, 01 reserved, 1x unsupported.
// - Config two bit 7 enables automatic fallback to bus power and return.
// - Config two bits 5:4 select overload delay 0.1, 2, 4 or 6 ms.
// - Config two bit 3 reports hub is part of a compound device.
// - Fixed port mask bits 1 and 2 mark ports fixed; others read zero.
// - Self powered: local port-off mask bits 1 and 2 disable ports.
// - Bus powered: upstream port-off mask bits 1 and 2 disable ports.
// - Local max draw value counts 2 mA steps; 50 means 100 mA.
// - Hardware reset clears every register in the bank to 0x00.
// - Once lock bit set, config range writes ignored until hardware reset.
package hpp_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] HPP_OFS_STATUS    = 8'h00;
	localparam logic [7:0] HPP_OFS_CFG_ONE   = 8'h07;
	localparam logic [7:0] HPP_OFS_CFG_TWO   = 8'h08;
	localparam logic [7:0] HPP_OFS_FIXED     = 8'h09;
	localparam logic [7:0] HPP_OFS_OFF_LOCAL = 8'h0a;
	localparam logic [7:0] HPP_OFS_OFF_UP    = 8'h0b;
	localparam logic [7:0] HPP_OFS_MAX_LOCAL = 8'h0c;
	localparam logic [7:0] HPP_OFS_LOCK_LO   = 8'h01;
	localparam logic [7:0] HPP_OFS_LOCK_HI   = 8'h10;

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int HPP_BIT_SRC_SEL     = 7;
	localparam int HPP_BIT_FAST_INH    = 5;
	localparam int HPP_BIT_EOP_SUPP    = 3;
	localparam int HPP_BIT_SENSE_LO    = 1;
	localparam int HPP_BIT_DYNAMIC     = 7;
	localparam int HPP_BIT_DELAY_LO    = 4;
	localparam int HPP_BIT_COMPOUND    = 3;
	localparam int HPP_BIT_LOCK        = 1;
	localparam logic [7:0] HPP_MASK_CFG_ONE = 8'hae;
	localparam logic [7:0] HPP_MASK_CFG_TWO = 8'hb8;
	localparam logic [7:0] HPP_MASK_PORTS   = 8'h06;
	localparam logic [7:0] HPP_MASK_STATUS  = 8'h02;
	localparam logic [7:0] HPP_RESET_VALUE  = 8'h00;

	// ------------------------------------------------------------
	// Overload delay times and cycle counts at 40 MHz
	// ------------------------------------------------------------
	localparam int HPP_CLK_HZ         = 40_000_000;
	localparam int HPP_DELAY_US_0     = 100;
	localparam int HPP_DELAY_US_1     = 2000;
	localparam int HPP_DELAY_US_2     = 4000;
	localparam int HPP_DELAY_US_3     = 6000;
	localparam int HPP_CYC_PER_US     = HPP_CLK_HZ / 1_000_000;
	localparam int HPP_DELAY_CYC_0    = HPP_DELAY_US_0 * HPP_CYC_PER_US;
	localparam int HPP_DELAY_CYC_1    = HPP_DELAY_US_1 * HPP_CYC_PER_US;
	localparam int HPP_DELAY_CYC_2    = HPP_DELAY_US_2 * HPP_CYC_PER_US;
	localparam int HPP_DELAY_CYC_3    = HPP_DELAY_US_3 * HPP_CYC_PER_US;
	localparam int HPP_DELAY_W        = 18;

	// Milliamps per count of the max draw value
	localparam int HPP_MA_PER_STEP    = 2;

	// Overload sense modes
	typedef enum logic [1:0] {
		HPP_SENSE_GANGED   = 2'b00,
		HPP_SENSE_RESERVED = 2'b01,
		HPP_SENSE_NONE_A   = 2'b10,
		HPP_SENSE_NONE_B   = 2'b11
	} hpp_sense_t;

endpackage

// [tb.sv]
// Self-checking bench for the configuration bank with a register model.
// Assumes the host model drives the register port; clock enable dropped once.
module tb
	import hpp_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       pin = 1'b0;
	logic       raw = 1'b0;
	logic       en = 1'b1;
	logic [7:0] addr, wdata, rdata, a, d;
	logic       wr, self_o, fast_o, eop_o, on_o, ovl_o, comp_o, lock_o;
	logic [1:0] mode_o, fix_o, en_o;
	logic [9:0] ma_o;
	logic [7:0] m [0:16];
	int         errors = 0;
	int         n_checks = 0;
	int         cy [4] = '{4, 8, 12, 16};
	always #12.5 clock_i = ~clock_i;
	// Short delays keep the timer scenario brief
	hpp_config_regs #(.CYC_0(4), .CYC_1(8), .CYC_2(12), .CYC_3(16)) DUT (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(en),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .local_power_sense_pin_i(pin),
		.overload_raw_i(raw), .self_powered_o(self_o),
		.fast_mode_inhibit_o(fast_o), .frame_end_packet_suppress_o(eop_o),
		.overload_sense_mode_o(mode_o), .overload_sense_on_o(on_o),
		.overload_o(ovl_o), .compound_o(comp_o), .fixed_port_bits_o(fix_o),
		.port_enabled_o(en_o), .max_draw_local_ma_o(ma_o),
		.config_locked_o(lock_o));
	hpp_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .wdata_o(wdata));
	// Stored bits of each configuration register; status is handled apart, everything else reads zero
	function automatic logic [7:0] msk(input logic [7:0] x);
		case (x)
			HPP_OFS_CFG_ONE: return HPP_MASK_CFG_ONE;
			HPP_OFS_CFG_TWO: return HPP_MASK_CFG_TWO;
			HPP_OFS_FIXED, HPP_OFS_OFF_LOCAL, HPP_OFS_OFF_UP: return HPP_MASK_PORTS;
			HPP_OFS_MAX_LOCAL: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// Lock bit can only be set; locked range writes leave the model alone
	task automatic put(input logic [7:0] x, input logic [7:0] v);
		host.wr(x, v);
		if (x == HPP_OFS_STATUS)
			m[0] = m[0] | (v & HPP_MASK_STATUS);
		else if (x <= HPP_OFS_LOCK_HI && !m[0][1])
			m[x] = v & msk(x);
	endtask
	task automatic verify();
		logic [7:0] q;
		logic       sp;
		for (int i = 0; i <= 16; i++) begin
			host.rd(8'(i), q);
			chk("rdata", m[i], q);
		end
		host.rd(8'h40, q);
		chk("undefined", 10'h000, q);
		sp = m[8][7] ? pin : m[7][7];
		chk("self", sp, self_o);
		chk("fast", m[7][5], fast_o);
		chk("eop", m[7][3], eop_o);
		chk("mode", m[7][2:1], mode_o);
		chk("sense_on", m[7][2:1] == 2'b00, on_o);
		chk("compound", m[8][3], comp_o);
		chk("fixed", m[9][2:1], fix_o);
		// Concatenation keeps the inversion two bits wide
		chk("ports", {~(sp ? m[10][2:1] : m[11][2:1])}, en_o);
		chk("max_ma", {m[12], 1'b0}, ma_o);
		chk("locked", m[0][1], lock_o);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#(25 * 20_000);
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hf72f));
		m = '{default: 8'h00};
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		verify();
		// Random legal host traffic across defined and undefined places
		repeat (80) begin
			a = 8'($urandom % 18 + 1);
			d = 8'($urandom) & msk(a);
			if (a == HPP_OFS_MAX_LOCAL) d = 8'($urandom % 51);
			if (a == HPP_OFS_CFG_ONE && d[2]) d[7] = 1'b0;
			@(posedge clock_i) pin <= 1'($urandom);
			put(a, d);
			verify();
		end
		// Reserved bits set on purpose must read back zero
		for (int i = 7; i <= 12; i++) put(8'(i), 8'hff);
		verify();
		// Write with clock enable low must leave the model's value alone
		@(posedge clock_i) en <= 1'b0;
		host.wr(HPP_OFS_MAX_LOCAL, 8'h21);
		@(posedge clock_i) en <= 1'b1;
		verify();
		// Overload delay for each selection, sensing ganged
		put(HPP_OFS_CFG_ONE, 8'h00);
		for (int s = 0; s < 4; s++) begin
			put(HPP_OFS_CFG_TWO, 8'(s << 4));
			@(posedge clock_i) raw <= 1'b1;
			repeat (cy[s] - 1) @(posedge clock_i);
			#1 chk("ovl_early", 10'h000, ovl_o);
			repeat (4) @(posedge clock_i);
			#1 chk("ovl_late", 10'h001, ovl_o);
			@(posedge clock_i) raw <= 1'b0;
			repeat (2) @(posedge clock_i);
			#1 chk("ovl_drop", 10'h000, ovl_o);
		end
		// Lock, then writes into the range and a clear attempt are dropped
		put(HPP_OFS_STATUS, 8'h02);
		put(HPP_OFS_CFG_ONE, 8'ha8);
		put(HPP_OFS_MAX_LOCAL, 8'h05);
		put(HPP_OFS_STATUS, 8'h00);
		verify();
		// Second reset mid-run clears lock and bank
		@(posedge clock_i) sys_rst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		m = '{default: 8'h00};
		verify();
		end_of_test();
	end
endmodule
